// file: bench/pad_load_model.sv
// Load model for the shared display pins.
// Assumes the bench sets the level each released pin settles to.
`timescale 1ns/1ps

// ****************
// Pad loads
// ****************
module pad_load_model (
	input wire logic [18:0] pad_out_i,
	input wire logic [18:0] pad_oe_n_i,
	input wire logic [18:0] load_lvl_i,
	output logic [18:0] pad_in_o
);
	// A released pin settles to its load level, never to the last driven value.
	// A driven pin shows the driver, so a read of an output pin sees its own data.
	always_comb begin
		for (int i = 0; i < 19; i++) begin
			pad_in_o[i] = pad_oe_n_i[i] ? load_lvl_i[i] : pad_out_i[i];
		end
	end
endmodule

// file: bench/testbench.sv
// Self-checking bench for the shared display pin block.
// Assumes the register header is on the include path.
`timescale 1ns/1ps
`include "pad_config_regs.svh"

`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
	$display("[ERR] %s exp %0h got %0h", nm, e, g); end end

module testbench
	import pad_config_pkg::*;
;
	// ****************
	// Signals and model state
	// ****************
	logic sys_clk_i, rst_i, wr_i, rd_i;
	logic [15:0] addr_i;
	logic [7:0] wdata_i, rdata_o;
	logic [18:0] pad_in, pad_out, oe_n, seg_en, lvl;
	logic [18:0][5:0] seg_data;
	supply_en_s sup;
	int miscompares, checked;
	logic [31:0] lf;
	logic [5:0] pw [19]; // Model of each pad word.
	logic [18:0] sel; // Model of the select bits.
	logic [1:0] mode; // Model of the supply mode.
	logic [15:0] pad_addr_gap [5] = '{16'h2400, 16'h2408, 16'h243E, 16'h2442, 16'h2448};

	segment_dio_pin_config dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pad_in_i(pad_in),
		.pad_out_o(pad_out), .pad_oe_n_o(oe_n), .seg_data_o(seg_data), .seg_en_o(seg_en),
		.supply_en_o(sup));
	pad_load_model load (.pad_out_i(pad_out), .pad_oe_n_i(oe_n), .load_lvl_i(lvl),
		.pad_in_o(pad_in));

	// Clock of 20 ns.
	initial begin
		sys_clk_i = 1'b0;
		forever #10 sys_clk_i = ~sys_clk_i;
	end

	// ****************
	// Helpers
	// ****************
	function automatic logic [31:0] rnd();
		lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
		return lf;
	endfunction

	// Pins 32-45 sit in one run, pins 51-55 in another.
	function automatic logic [15:0] pad_addr(input int i);
		return (i < 14) ? 16'(16'h2430 + i) : 16'(16'h2443 + i - 14);
	endfunction

	// One register cycle; strobes drop one edge later so nothing toggles twice.
	task wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		#1;
		addr_i = a;
		wdata_i = d;
		wr_i = 1'b1;
		@(posedge sys_clk_i);
		#1;
		wr_i = 1'b0;
	endtask

	task rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge sys_clk_i);
		#1;
		addr_i = a;
		rd_i = 1'b1;
		@(posedge sys_clk_i);
		#1;
		rd_i = 1'b0;
		d = rdata_o;
	endtask

	task model_clear();
		sel = '0;
		mode = 2'h0;
		for (int i = 0; i < 19; i++) pw[i] = 6'h00;
	endtask

	// Reads every mapped register and checks every pin against the model.
	task check_all();
		logic [7:0] d;
		logic [7:0] e;
		for (int i = 0; i < 19; i++) begin
			rd(pad_addr(i), d);
			// An input pin in general-purpose mode reads its pad level.
			e = {2'h0, pw[i][5:1], (!sel[i] && !pw[i][1]) ? lvl[i] : pw[i][0]};
			`CHK("pad word", e, d)
			`CHK("seg data", sel[i] ? pw[i] : 6'h00, seg_data[i])
			`CHK("oe_n", !(!sel[i] && pw[i][1]), oe_n[i])
			if (!sel[i] && pw[i][1]) `CHK("pad out", pw[i][0], pad_out[i])
			else if (sel[i]) `CHK("pad out", 1'b0, pad_out[i])
		end
		rd(16'h2407, d);
		`CHK("select low", sel[7:0], d)
		rd(16'h2406, d);
		`CHK("select mid", {2'h0, sel[13:8]}, d)
		rd(16'h2405, d);
		`CHK("select high", {sel[18:14], 3'h0}, d)
		`CHK("seg enable", sel, seg_en)
		rd(16'h2401, d);
		`CHK("mode", {mode, 6'h00}, d)
	endtask

	task final_report();
		$display("checks %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Cuts a hang short.
	initial begin
		repeat (100000) @(posedge sys_clk_i);
		miscompares++;
		$display("[ERR] run time exp done got hang");
		final_report();
	end

	// ****************
	// Main sequence
	// ****************
	initial begin
		logic [31:0] r;
		logic [7:0] d;
		rst_i = 1'b1;
		wr_i = 1'b0;
		rd_i = 1'b0;
		addr_i = 16'h0000;
		wdata_i = 8'h00;
		lvl = '0;
		lf = 32'h53CC;
		miscompares = 0;
		checked = 0;
		model_clear();
		repeat (20) @(posedge sys_clk_i);
		#1;
		rst_i = 1'b0;
		check_all();
		$display("test reset done");
		// Every supply code, with noise in the unused low bits.
		for (int m = 0; m < 4; m++) begin
			r = rnd();
			wr(16'h2401, {m[1:0], r[5:0]});
			mode = m[1:0];
			`CHK("supply", {mode == 2'h3, mode[0] ^ mode[1], mode == 2'h2}, sup)
			rd(16'h2401, d);
			`CHK("mode", {mode, 6'h00}, d)
		end
		$display("test supply done");
		// Random words, selects and loads across all pins.
		for (int k = 0; k < 4; k++) begin
			for (int i = 0; i < 19; i++) begin
				r = rnd();
				wr(pad_addr(i), r[7:0]);
				pw[i] = r[5:0];
			end
			r = rnd();
			wr(16'h2407, r[7:0]);
			wr(16'h2406, r[15:8]);
			wr(16'h2405, r[23:16]);
			sel = {r[23:19], r[13:8], r[7:0]};
			r = rnd();
			lvl = r[18:0];
			check_all();
		end
		$display("test pins done");
		// Unmapped places neither store nor disturb mapped ones.
		foreach (pad_addr_gap[j]) begin
			wr(pad_addr_gap[j], 8'hFF);
			rd(pad_addr_gap[j], d);
			`CHK("unmapped", 8'h00, d)
		end
		check_all();
		$display("test unmapped done");
		// A reset in mid-run clears everything again.
		rst_i = 1'b1;
		repeat (2) @(posedge sys_clk_i);
		#1;
		rst_i = 1'b0;
		model_clear();
		check_all();
		`CHK("supply", 3'h0, sup)
		$display("test rerun done");
		final_report();
	end
endmodule

// file: logic/pad_config_pkg.sv
// Types shared by the shared display pin block and its pad cell.
// Assumes the register header is on the include path.
`include "pad_config_regs.svh"

package pad_config_pkg;

	// ****************************************************************
	// Carrier types
	// ****************************************************************

	// Decoded display supply enables.
	typedef struct packed {
		logic external_supply_enable;
		logic contrast_dac_enable;
		logic voltage_boost_enable;
	} supply_en_s;

	// One segment data word, one bit per backplane phase.
	typedef logic [`SEG_BITS-1:0] seg_word_t;

	// Drive of one shared pin toward its pad.
	typedef struct packed {
		logic pad_out;
		logic pad_oe_n;
	} pad_drive_s;

	// Complete register state of the block.
	typedef struct packed {
		logic [1:0] display_supply_mode;
		logic [`PAD_COUNT-1:0] pin_function_select;
		logic [`PAD_COUNT-1:0][`SEG_BITS-1:0] pad_control_word;
		logic [7:0] rdata;
	} cfg_state_s;

endpackage

// file: logic/pad_config_regs.svh
// Register map, field positions and reset values of the shared display pin block.
// Assumes byte-wide I/O RAM addressing with 16-bit addresses.
`ifndef PAD_CONFIG_REGS_SVH
`define PAD_CONFIG_REGS_SVH

// ****************************************************************
// Address map
// ****************************************************************
`define SUPPLY_MODE_ADDR 16'h2401
`define SELECT_55_51_ADDR 16'h2405
`define SELECT_45_40_ADDR 16'h2406
`define SELECT_39_32_ADDR 16'h2407
`define PAD32_ADDR 16'h2430
`define PAD45_ADDR 16'h243D
`define PAD51_ADDR 16'h2443
`define PAD55_ADDR 16'h2447

// ****************************************************************
// Field positions and counts
// ****************************************************************
`define SUPPLY_MODE_MSB 7
`define SUPPLY_MODE_LSB 6
`define SELECT_55_51_LSB 3
`define PAD_DATA_BIT 0
`define PAD_DIR_BIT 1
`define LOW_GROUP_COUNT 14
`define PAD_COUNT 19
`define SEG_BITS 6
`define BACKPLANE_COUNT 6

// ****************************************************************
// Supply mode encodings and reset values
// ****************************************************************
`define MODE_INTERNAL 2'h0
`define MODE_DAC_ONLY 2'h1
`define MODE_DAC_BOOST 2'h2
`define MODE_EXTERNAL 2'h3
`define SUPPLY_MODE_RESET 2'h0
`define PIN_SELECT_RESET 19'h00000
`define PAD_CTRL_RESET 6'h00

`endif

// file: logic/segment_dio_pin_config.sv
// Configuration registers and pin steering for shared display pins 32-45 and 51-55,
// plus the decode of the display supply mode into three enables.
// Assumes the processor reaches the byte-wide I/O RAM through a single-cycle port.
`timescale 1ns/1ps
`include "pad_config_regs.svh"

// Behaviour
// - Segment outputs, six bits per pin, per backplane.
// - Select bit: clear general-purpose, set display segment.
// - Pins 32-45 hold six segment bits each.
// - Pins 51-55 hold six segment bits each.
// - Pins 32-45 general-purpose data is bit zero.
// - Pins 32-45 direction bit one, one means output.
// - Pins 51-55 data bit zero, direction bit one.
// - Supply mode bits seven:six decode to three enables.
// - Mode 11 asserts external supply only.
// - Mode 10 asserts contrast DAC and boost.
// - Mode 01 asserts contrast DAC only.
// - Mode 00 deasserts all three enables.
module segment_dio_pin_config
	import pad_config_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [15:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic [`PAD_COUNT-1:0] pad_in_i,
	output logic [`PAD_COUNT-1:0] pad_out_o,
	output logic [`PAD_COUNT-1:0] pad_oe_n_o,
	output logic [`PAD_COUNT-1:0][`SEG_BITS-1:0] seg_data_o,
	output logic [`PAD_COUNT-1:0] seg_en_o,
	output supply_en_s supply_en_o
);

	// ****************************************************************
	// State and decode
	// ****************************************************************

	cfg_state_s state_ff; // All registers of the block.
	cfg_state_s nxt_state; // Next value of the register state.
	logic [`PAD_COUNT-1:0] read_bit0; // Bit 0 as software sees it, per pin.
	logic pad_hit; // Address falls on a pad control word.
	logic [4:0] pad_idx; // Pad index of the current address.
	logic [7:0] read_value; // Byte presented for a read this cycle.
	logic [`PAD_COUNT-1:0] dir_bits; // Direction bit of each pad word, watched by the checks.

	// Map the address onto a pad index: 0-13 for pins 32-45, 14-18 for 51-55.
	// The gap between the two runs decodes as unmapped, so stray writes there are lost.
	always_comb begin
		pad_hit = 1'b0;
		pad_idx = 5'h00;
		if (addr_i >= `PAD32_ADDR && addr_i <= `PAD45_ADDR) begin
			// Lower run: one word per pin, pins 32 to 45 in order.
			pad_hit = 1'b1;
			pad_idx = 5'(addr_i - `PAD32_ADDR);
		end else if (addr_i >= `PAD51_ADDR && addr_i <= `PAD55_ADDR) begin
			// Upper run: pins 51 to 55 follow the fourteen lower words.
			pad_hit = 1'b1;
			pad_idx = 5'(addr_i - `PAD51_ADDR + `LOW_GROUP_COUNT);
		end
	end

	// ****************************************************************
	// Pad cells
	// ****************************************************************

	// One steering cell per shared pin; the indices line up with the pad words.
	genvar gi;
	generate
		for (gi = 0; gi < `PAD_COUNT; gi++) begin : g_pad
			pad_drive_s drive;
			shared_pad_cell u_cell (
				.select_i(state_ff.pin_function_select[gi]),
				.ctrl_i(state_ff.pad_control_word[gi]),
				.pad_in_i(pad_in_i[gi]),
				.drive_o(drive),
				.seg_data_o(seg_data_o[gi]),
				.read_bit0_o(read_bit0[gi])
			);
			assign pad_out_o[gi] = drive.pad_out;
			assign pad_oe_n_o[gi] = drive.pad_oe_n;
			assign dir_bits[gi] = state_ff.pad_control_word[gi][`PAD_DIR_BIT];
		end
	endgenerate

	// Each segment-mode pin carries one bit per backplane phase.
	assign seg_en_o = state_ff.pin_function_select;

	// ****************************************************************
	// Register read mux
	// ****************************************************************

	// Unmapped addresses and unused bits read as zero.
	always_comb begin
		read_value = 8'h00;
		if (pad_hit) begin
			// Bit 0 comes through the cell, so an input pin shows its pad level.
			read_value = {2'h0, state_ff.pad_control_word[pad_idx][`SEG_BITS-1:1],
				read_bit0[pad_idx]};
		end else begin
			unique case (addr_i)
				`SUPPLY_MODE_ADDR: read_value = {state_ff.display_supply_mode, 6'h00};
				`SELECT_55_51_ADDR: read_value = {state_ff.pin_function_select[18:14], 3'h0};
				`SELECT_45_40_ADDR: read_value = {2'h0, state_ff.pin_function_select[13:8]};
				`SELECT_39_32_ADDR: read_value = state_ff.pin_function_select[7:0];
				default: read_value = 8'h00;
			endcase
		end
	end

	// ****************************************************************
	// Next state
	// ****************************************************************

	// Writes land in one cycle; reads are answered from a flip-flop one cycle later.
	always_comb begin
		nxt_state = state_ff;
		// Only the stored bits of each register are kept; the rest fall away.
		if (wr_i) begin
			if (pad_hit) begin
				nxt_state.pad_control_word[pad_idx] = wdata_i[`SEG_BITS-1:0];
			end else begin
				unique case (addr_i)
					`SUPPLY_MODE_ADDR: begin
						nxt_state.display_supply_mode =
							wdata_i[`SUPPLY_MODE_MSB:`SUPPLY_MODE_LSB];
					end
					`SELECT_55_51_ADDR: begin
						nxt_state.pin_function_select[18:14] = wdata_i[7:3];
					end
					`SELECT_45_40_ADDR: begin
						nxt_state.pin_function_select[13:8] = wdata_i[5:0];
					end
					`SELECT_39_32_ADDR: begin
						nxt_state.pin_function_select[7:0] = wdata_i;
					end
					default: begin
						nxt_state.rdata = state_ff.rdata;
					end
				endcase
			end
		end
		// A read in the same cycle as a write still returns the old contents.
		if (rd_i) begin
			nxt_state.rdata = read_value;
		end
	end

	// Reset leaves every pin a general-purpose input and the display on the rail.
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			// Constants only, so the reset path never depends on clocked logic.
			state_ff.display_supply_mode <= `SUPPLY_MODE_RESET;
			state_ff.pin_function_select <= `PIN_SELECT_RESET;
			state_ff.pad_control_word <= '0;
			state_ff.rdata <= 8'h00;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign rdata_o = state_ff.rdata;

	// ****************************************************************
	// Supply mode decode
	// ****************************************************************

	// Pure decode of the stored field, so the enables never lag the register.
	// Mode 00 keeps every helper off, which is the lowest battery drain.
	always_comb begin
		unique case (state_ff.display_supply_mode)
			`MODE_EXTERNAL: supply_en_o = '{1'b1, 1'b0, 1'b0};
			`MODE_DAC_BOOST: supply_en_o = '{1'b0, 1'b1, 1'b1};
			`MODE_DAC_ONLY: supply_en_o = '{1'b0, 1'b1, 1'b0};
			`MODE_INTERNAL: supply_en_o = '{1'b0, 1'b0, 1'b0};
		endcase
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	// Mode write takes effect on the very next cycle.
	a_mode_write_enables: assert property (
		(wr_i && addr_i == `SUPPLY_MODE_ADDR) |=>
		supply_en_o.external_supply_enable == ($past(wdata_i[7]) & $past(wdata_i[6])))
		else $error("supply enable lagged a mode write");

	// Code 11 hands the display supply to an outside source.
	a_mode_ext_only: assert property (
		state_ff.display_supply_mode == `MODE_EXTERNAL |->
		supply_en_o == '{1'b1, 1'b0, 1'b0})
		else $error("mode 11 decode wrong");

	// Code 10 runs the contrast DAC through the boost stage.
	a_mode_dac_boost: assert property (
		state_ff.display_supply_mode == `MODE_DAC_BOOST |->
		supply_en_o == '{1'b0, 1'b1, 1'b1})
		else $error("mode 10 decode wrong");

	// Code 01 runs the contrast DAC without boost.
	a_mode_dac_only: assert property (
		state_ff.display_supply_mode == `MODE_DAC_ONLY |->
		supply_en_o == '{1'b0, 1'b1, 1'b0})
		else $error("mode 01 decode wrong");

	// Code 00 leaves the display on the internal rail with every helper off.
	a_mode_all_off: assert property (
		(wr_i && addr_i == `SUPPLY_MODE_ADDR && wdata_i[7:6] == 2'h0) |=>
		supply_en_o == '{1'b0, 1'b0, 1'b0})
		else $error("mode 00 left an enable on");

	a_segment_no_drive: assert property (
		(wr_i && addr_i == `SELECT_39_32_ADDR && wdata_i[0]) |=>
		pad_oe_n_o[0] && seg_en_o[0])
		else $error("segment pin still driven as general-purpose");

	a_pad32_seg_data: assert property (
		(wr_i && addr_i == `PAD32_ADDR && state_ff.pin_function_select[0]) |=>
		seg_data_o[0] == $past(wdata_i[5:0]))
		else $error("pin 32 segment data not stored");

	a_pad55_seg_data: assert property (
		(wr_i && addr_i == `PAD55_ADDR && state_ff.pin_function_select[18]) |=>
		seg_data_o[18] == $past(wdata_i[5:0]))
		else $error("pin 55 segment data not stored");

	a_gpio_out_drive: assert property (
		(!state_ff.pin_function_select[5] && state_ff.pad_control_word[5][1]) |->
		!pad_oe_n_o[5] && pad_out_o[5] == state_ff.pad_control_word[5][0])
		else $error("output pin 37 not driving its data bit");

	a_gpio51_input: assert property (
		(wr_i && addr_i == `PAD51_ADDR && !wdata_i[1] && !state_ff.pin_function_select[14])
		|=> pad_oe_n_o[14])
		else $error("input pin 51 is driving");

	// A set data bit on an output pin drives high and stays so until software touches the pin again.
	a_gpio_data_bit: assert property (
		(wr_i && addr_i == `PAD32_ADDR && wdata_i[1:0] == 2'h3
		&& !state_ff.pin_function_select[0]) |=> pad_out_o[0] ##1
		(pad_out_o[0] || $changed(state_ff.pad_control_word[0])
		|| $changed(state_ff.pin_function_select[0])))
		else $error("pin 32 data bit not driven");

	a_read_mode_back: assert property (
		(rd_i && !wr_i && addr_i == `SUPPLY_MODE_ADDR) |=>
		rdata_o == {state_ff.display_supply_mode, 6'h00})
		else $error("supply mode read back wrong");

	// A mode write sets the contrast DAC enable for codes 01 and 10 on the next cycle.
	a_mode_write_dac: assert property (
		(wr_i && addr_i == `SUPPLY_MODE_ADDR) |=>
		supply_en_o.contrast_dac_enable == ($past(wdata_i[7]) ^ $past(wdata_i[6])))
		else $error("contrast enable lagged a mode write");

	// Only code 10 turns the boost on.
	a_mode_write_boost: assert property (
		(wr_i && addr_i == `SUPPLY_MODE_ADDR) |=>
		supply_en_o.voltage_boost_enable == ($past(wdata_i[7]) & !$past(wdata_i[6])))
		else $error("boost enable lagged a mode write");

	// No segment pin may drive its pad or leave a stray data level on it.
	a_segment_release_all: assert property (
		(state_ff.pin_function_select & ~pad_oe_n_o) == '0
		&& (state_ff.pin_function_select & pad_out_o) == '0)
		else $error("segment pin left a general-purpose driver on");

	// General-purpose pins show no segment data to the display driver.
	a_gpio_seg_quiet: assert property (
		!state_ff.pin_function_select[18] |-> seg_data_o[18] == '0)
		else $error("pin 55 shows segment data in general-purpose mode");

	// A general-purpose pin drives exactly when its direction bit is one.
	a_gpio_dir_enable: assert property (
		((~state_ff.pin_function_select) & (dir_bits ^ ~pad_oe_n_o)) == '0)
		else $error("pin drive does not follow its direction bit");

	// An output pin of the upper run drives its stored data bit.
	a_gpio51_out_drive: assert property (
		(!state_ff.pin_function_select[14] && state_ff.pad_control_word[14][1]) |->
		!pad_oe_n_o[14] && pad_out_o[14] == state_ff.pad_control_word[14][0])
		else $error("output pin 51 not driving its data bit");

	// An input pin reads back the level its pad had at the read edge.
	a_input_read_level: assert property (
		(rd_i && addr_i == `PAD32_ADDR && !state_ff.pin_function_select[0]
		&& !state_ff.pad_control_word[0][1]) |=> rdata_o[0] == $past(pad_in_i[0]))
		else $error("input pin 32 did not read its pad level");

	// Reads beyond the upper run return zero.
	a_unmapped_read_zero: assert property (
		(rd_i && addr_i > `PAD55_ADDR) |=> rdata_o == 8'h00)
		else $error("unmapped address read non-zero");

	// Select bits of pins 32-39 read back as stored.
	a_select_readback: assert property (
		(rd_i && !wr_i && addr_i == `SELECT_39_32_ADDR) |=>
		rdata_o == $past(state_ff.pin_function_select[7:0]))
		else $error("select bits read back wrong");

	c_mode_boost: cover property (state_ff.display_supply_mode == `MODE_DAC_BOOST);
	c_segment_pin: cover property (seg_en_o[18] && seg_data_o[18] != '0);
	c_gpio_output: cover property (!pad_oe_n_o[0] && pad_out_o[0]);
	c_input_read: cover property (rd_i && addr_i == `PAD51_ADDR && pad_oe_n_o[14]);
	c_mode_external: cover property (supply_en_o.external_supply_enable);

endmodule

// file: logic/shared_pad_cell.sv
// Per-pin function steering for one shared display pin.
// Assumes the control word and select bit come from flip-flops in the parent.
`timescale 1ns/1ps
`include "pad_config_regs.svh"

module shared_pad_cell
	import pad_config_pkg::*;
(
	input wire logic select_i,
	input wire seg_word_t ctrl_i,
	input wire logic pad_in_i,
	output pad_drive_s drive_o,
	output seg_word_t seg_data_o,
	output logic read_bit0_o
);

	// ****************************************************************
	// Function steering
	// ****************************************************************

	// A set select bit hands the pin to the display driver; a clear one
	// makes it a general-purpose pin with data in bit 0, direction in bit 1.
	always_comb begin
		if (select_i) begin
			drive_o.pad_out = 1'b0;
			drive_o.pad_oe_n = 1'b1;
			seg_data_o = ctrl_i;
		end else begin
			drive_o.pad_out = ctrl_i[`PAD_DATA_BIT];
			drive_o.pad_oe_n = ~ctrl_i[`PAD_DIR_BIT];
			seg_data_o = '0;
		end
	end

	// An input-mode pin reads its pad level; everything else reads the stored bit.
	assign read_bit0_o = (!select_i && !ctrl_i[`PAD_DIR_BIT]) ? pad_in_i : ctrl_i[`PAD_DATA_BIT];

endmodule
